// *** hw/coa_operand_addressing.v ***
`timescale 1ns/10ps
// Summary of operation
// - direct 8-bit field reaches ram or sfr
// - 8-bit indirect via bank pointer zero/one
// - 16-bit indirect uses data pointer
// - opcode low bits select bank register
// - implied operand, no specifier decoded
// - immediate bytes are data, not address
// - code read at data pointer plus accumulator
// - bit operand from 256-bit space
// - address formed in one clock
// - classic opcode encodings kept
// - held in reset while pin low
// - low 128 bits ram, rest sfr
module coa_operand_addressing (
  input wire core_clk_i,
  input wire nrst_i,
  input wire decode_valid_i,
  input wire [7:0] opcode_i,
  input wire [7:0] operand_byte1_i,
  input wire [7:0] operand_byte2_i,
  input wire [7:0] accumulator_i,
  input wire [15:0] data_pointer_i,
  input wire [7:0] status_word_i,
  input wire [7:0] indirect_pointer_zero_i,
  input wire [7:0] indirect_pointer_one_i,
  output reg addr_valid_o,
  output reg [2:0] addr_space_o,
  output reg [2:0] addr_mode_o,
  output reg [15:0] operand_addr_o,
  output reg [7:0] immediate_o,
  output reg [2:0] bit_pos_o,
  output reg [2:0] reg_index_o
);
`include "coa_defs.vh"
  wire [1:0] bank_sel;
  wire [7:0] bank_base;
  wire [7:0] bit_byte;
  wire [2:0] bit_pos;
  wire bit_is_sfr;
  reg [2:0] mode_d;
  reg [2:0] space_d;
  reg [15:0] addr_d;
  reg [7:0] imm_d;
  reg [2:0] idx_d;
  reg [7:0] dir_byte;
  reg [7:0] bit_field;
  reg dir_imm;
  assign bank_sel = status_word_i[`COA_PSW_BANK_LSB+1:`COA_PSW_BANK_LSB];
  assign bank_base = {3'h0, bank_sel, 3'h0};
  coa_bit_map u_bit_map (
    .bit_addr_i(bit_field),
    .byte_addr_o(bit_byte),
    .bit_pos_o(bit_pos),
    .is_sfr_o(bit_is_sfr)
  );
  always @* begin
    mode_d = `COA_MODE_NONE;
    dir_byte = operand_byte1_i;
    bit_field = operand_byte1_i;
    idx_d = opcode_i[2:0];
    imm_d = `COA_RST_DATA;
    dir_imm = 1'b0;
    if (opcode_i[3]) begin
      mode_d = `COA_MODE_REG;
    end else begin
      case (opcode_i[2:0])
        3'h0: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IMPL;
            4'h1: mode_d = `COA_MODE_BIT;
            4'h2: mode_d = `COA_MODE_BIT;
            4'h3: mode_d = `COA_MODE_BIT;
            4'h4: mode_d = `COA_MODE_IMPL;
            4'h5: mode_d = `COA_MODE_IMPL;
            4'h6: mode_d = `COA_MODE_IMPL;
            4'h7: mode_d = `COA_MODE_IMPL;
            4'h8: mode_d = `COA_MODE_IMPL;
            4'h9: mode_d = `COA_MODE_IMM;
            4'hA: mode_d = `COA_MODE_BIT;
            4'hB: mode_d = `COA_MODE_BIT;
            4'hC: mode_d = `COA_MODE_DIRECT;
            4'hD: mode_d = `COA_MODE_DIRECT;
            4'hE: mode_d = `COA_MODE_IND16;
            4'hF: mode_d = `COA_MODE_IND16;
            default: mode_d = `COA_MODE_IMPL;
          endcase
        end
        3'h1: begin
          // absolute jumps and calls
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IMPL;
            4'h1: mode_d = `COA_MODE_IMPL;
            4'h2: mode_d = `COA_MODE_IMPL;
            4'h3: mode_d = `COA_MODE_IMPL;
            4'h4: mode_d = `COA_MODE_IMPL;
            4'h5: mode_d = `COA_MODE_IMPL;
            4'h6: mode_d = `COA_MODE_IMPL;
            4'h7: mode_d = `COA_MODE_IMPL;
            4'h8: mode_d = `COA_MODE_IMPL;
            4'h9: mode_d = `COA_MODE_IMPL;
            4'hA: mode_d = `COA_MODE_IMPL;
            4'hB: mode_d = `COA_MODE_IMPL;
            4'hC: mode_d = `COA_MODE_IMPL;
            4'hD: mode_d = `COA_MODE_IMPL;
            4'hE: mode_d = `COA_MODE_IMPL;
            4'hF: mode_d = `COA_MODE_IMPL;
            default: mode_d = `COA_MODE_IMPL;
          endcase
        end
        3'h2: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IMPL;
            4'h1: mode_d = `COA_MODE_IMPL;
            4'h2: mode_d = `COA_MODE_IMPL;
            4'h3: mode_d = `COA_MODE_IMPL;
            4'h4: mode_d = `COA_MODE_DIRECT;
            4'h5: mode_d = `COA_MODE_DIRECT;
            4'h6: mode_d = `COA_MODE_DIRECT;
            4'h7: mode_d = `COA_MODE_BIT;
            4'h8: mode_d = `COA_MODE_BIT;
            4'h9: mode_d = `COA_MODE_BIT;
            4'hA: mode_d = `COA_MODE_BIT;
            4'hB: mode_d = `COA_MODE_BIT;
            4'hC: mode_d = `COA_MODE_BIT;
            4'hD: mode_d = `COA_MODE_BIT;
            4'hE: mode_d = `COA_MODE_IND8;
            4'hF: mode_d = `COA_MODE_IND8;
            default: mode_d = `COA_MODE_IMPL;
          endcase
        end
        3'h3: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IMPL;
            4'h1: mode_d = `COA_MODE_IMPL;
            4'h2: mode_d = `COA_MODE_IMPL;
            4'h3: mode_d = `COA_MODE_IMPL;
            4'h4, 4'h5, 4'h6: begin
              // direct target, constant in second byte
              mode_d = `COA_MODE_DIRECT;
              dir_imm = 1'b1;
            end
            4'h7: mode_d = `COA_MODE_IMPL;
            4'h8: mode_d = `COA_MODE_IND16;
            4'h9: mode_d = `COA_MODE_IND16;
            4'hA: mode_d = `COA_MODE_IMPL;
            4'hB: mode_d = `COA_MODE_IMPL;
            4'hC: mode_d = `COA_MODE_IMPL;
            4'hD: mode_d = `COA_MODE_IMPL;
            4'hE: mode_d = `COA_MODE_IND8;
            4'hF: mode_d = `COA_MODE_IND8;
            default: mode_d = `COA_MODE_IMPL;
          endcase
        end
        3'h4: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IMPL;
            4'h1: mode_d = `COA_MODE_IMPL;
            4'h2: mode_d = `COA_MODE_IMM;
            4'h3: mode_d = `COA_MODE_IMM;
            4'h4: mode_d = `COA_MODE_IMM;
            4'h5: mode_d = `COA_MODE_IMM;
            4'h6: mode_d = `COA_MODE_IMM;
            4'h7: mode_d = `COA_MODE_IMM;
            4'h8: mode_d = `COA_MODE_IMPL;
            4'h9: mode_d = `COA_MODE_IMM;
            4'hA: mode_d = `COA_MODE_IMPL;
            4'hB: mode_d = `COA_MODE_IMM;
            4'hC: mode_d = `COA_MODE_IMPL;
            4'hD: mode_d = `COA_MODE_IMPL;
            4'hE: mode_d = `COA_MODE_IMPL;
            4'hF: mode_d = `COA_MODE_IMPL;
            default: mode_d = `COA_MODE_IMPL;
          endcase
        end
        3'h5: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_DIRECT;
            4'h1: mode_d = `COA_MODE_DIRECT;
            4'h2: mode_d = `COA_MODE_DIRECT;
            4'h3: mode_d = `COA_MODE_DIRECT;
            4'h4: mode_d = `COA_MODE_DIRECT;
            4'h5: mode_d = `COA_MODE_DIRECT;
            4'h6: mode_d = `COA_MODE_DIRECT;
            4'h7: begin
              mode_d = `COA_MODE_DIRECT;
              dir_imm = 1'b1;
            end
            4'h8: mode_d = `COA_MODE_DIRECT;
            4'h9: mode_d = `COA_MODE_DIRECT;
            4'hA: mode_d = `COA_MODE_DIRECT;
            4'hB: mode_d = `COA_MODE_DIRECT;
            4'hC: mode_d = `COA_MODE_DIRECT;
            4'hD: mode_d = `COA_MODE_DIRECT;
            4'hE: mode_d = `COA_MODE_DIRECT;
            4'hF: mode_d = `COA_MODE_DIRECT;
            default: mode_d = `COA_MODE_DIRECT;
          endcase
        end
        3'h6: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IND8;
            4'h1: mode_d = `COA_MODE_IND8;
            4'h2: mode_d = `COA_MODE_IND8;
            4'h3: mode_d = `COA_MODE_IND8;
            4'h4: mode_d = `COA_MODE_IND8;
            4'h5: mode_d = `COA_MODE_IND8;
            4'h6: mode_d = `COA_MODE_IND8;
            4'h7: mode_d = `COA_MODE_IND8;
            4'h8: mode_d = `COA_MODE_IND8;
            4'h9: mode_d = `COA_MODE_IND8;
            4'hA: mode_d = `COA_MODE_IND8;
            4'hB: mode_d = `COA_MODE_IND8;
            4'hC: mode_d = `COA_MODE_IND8;
            4'hD: mode_d = `COA_MODE_IND8;
            4'hE: mode_d = `COA_MODE_IND8;
            4'hF: mode_d = `COA_MODE_IND8;
            default: mode_d = `COA_MODE_IND8;
          endcase
        end
        3'h7: begin
          case (opcode_i[7:4])
            4'h0: mode_d = `COA_MODE_IND8;
            4'h1: mode_d = `COA_MODE_IND8;
            4'h2: mode_d = `COA_MODE_IND8;
            4'h3: mode_d = `COA_MODE_IND8;
            4'h4: mode_d = `COA_MODE_IND8;
            4'h5: mode_d = `COA_MODE_IND8;
            4'h6: mode_d = `COA_MODE_IND8;
            4'h7: mode_d = `COA_MODE_IND8;
            4'h8: mode_d = `COA_MODE_IND8;
            4'h9: mode_d = `COA_MODE_IND8;
            4'hA: mode_d = `COA_MODE_IND8;
            4'hB: mode_d = `COA_MODE_IND8;
            4'hC: mode_d = `COA_MODE_IND8;
            4'hD: mode_d = `COA_MODE_IND8;
            4'hE: mode_d = `COA_MODE_IND8;
            4'hF: mode_d = `COA_MODE_IND8;
            default: mode_d = `COA_MODE_IND8;
          endcase
        end
        default: begin
          mode_d = `COA_MODE_IMPL;
        end
      endcase
    end
    space_d = `COA_SPACE_NONE;
    addr_d = `COA_RST_ADDR;
    case (mode_d)
      `COA_MODE_DIRECT: begin
        space_d = (dir_byte >= `COA_SFR_BASE) ? `COA_SPACE_SFR : `COA_SPACE_IRAM;
        addr_d = {8'h00, dir_byte};
        if (dir_imm) begin
          imm_d = operand_byte2_i;
        end
      end
      `COA_MODE_IND8: begin
        space_d = (opcode_i[7:5] == 3'h7 && !opcode_i[2]) ? `COA_SPACE_XDATA : `COA_SPACE_IRAM;
        addr_d = {8'h00, opcode_i[0] ? indirect_pointer_one_i : indirect_pointer_zero_i};
      end
      `COA_MODE_IND16: begin
        if (opcode_i == 8'h93 || opcode_i == 8'h83) begin
          space_d = `COA_SPACE_CODE;
          addr_d = data_pointer_i + {8'h00, accumulator_i};
        end else begin
          space_d = `COA_SPACE_XDATA;
          addr_d = data_pointer_i;
        end
      end
      `COA_MODE_REG: begin
        space_d = `COA_SPACE_IRAM;
        addr_d = {8'h00, bank_base | {5'h00, opcode_i[2:0]}};
      end
      `COA_MODE_IMM: begin
        space_d = `COA_SPACE_IMM;
        imm_d = operand_byte1_i;
      end
      `COA_MODE_BIT: begin
        space_d = `COA_SPACE_BIT;
        addr_d = {8'h00, bit_byte};
      end
      default: begin
        space_d = `COA_SPACE_IMPL;
      end
    endcase
  end
  always @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      addr_valid_o <= 1'b0;
      addr_space_o <= `COA_SPACE_NONE;
      addr_mode_o <= `COA_MODE_NONE;
      operand_addr_o <= `COA_RST_ADDR;
      immediate_o <= `COA_RST_DATA;
      bit_pos_o <= 3'h0;
      reg_index_o <= 3'h0;
    end else begin
      addr_valid_o <= decode_valid_i;
      if (decode_valid_i) begin
        addr_space_o <= (mode_d == `COA_MODE_BIT && !bit_is_sfr) ? `COA_SPACE_BIT : space_d;
        addr_mode_o <= mode_d;
        operand_addr_o <= addr_d;
        immediate_o <= imm_d;
        bit_pos_o <= bit_pos;
        reg_index_o <= idx_d;
      end
    end
  end
endmodule // coa_operand_addressing

// *** include/coa_defs.vh ***
`ifndef COA_DEFS_VH
`define COA_DEFS_VH
// address space selectors
`define COA_SPACE_NONE 3'h0
`define COA_SPACE_IRAM 3'h1
`define COA_SPACE_SFR 3'h2
`define COA_SPACE_XDATA 3'h3
`define COA_SPACE_CODE 3'h4
`define COA_SPACE_BIT 3'h5
`define COA_SPACE_IMM 3'h6
`define COA_SPACE_IMPL 3'h7
// operand kind codes
`define COA_MODE_NONE 3'h0
`define COA_MODE_DIRECT 3'h1
`define COA_MODE_IND8 3'h2
`define COA_MODE_IND16 3'h3
`define COA_MODE_REG 3'h4
`define COA_MODE_IMPL 3'h5
`define COA_MODE_IMM 3'h6
`define COA_MODE_BIT 3'h7
// internal ram / sfr split of the 8-bit direct space
`define COA_SFR_BASE 8'h80
// bit space split and byte bases
`define COA_BIT_RAM_LIMIT 8'h80
`define COA_BIT_RAM_BASE 8'h20
`define COA_BIT_SFR_MASK 8'hF8
// status word bank select field
`define COA_PSW_BANK_LSB 3
`define COA_BANK_SIZE_LOG2 3
// reset values
`define COA_RST_ADDR 16'h0000
`define COA_RST_DATA 8'h00
`endif

// *** hw/coa_bit_map.v ***
`timescale 1ns/10ps
module coa_bit_map (
  input wire [7:0] bit_addr_i,
  output wire [7:0] byte_addr_o,
  output wire [2:0] bit_pos_o,
  output wire is_sfr_o
);
`include "coa_defs.vh"
  // lower half maps onto ram bytes, upper half onto sfr bytes ending in 0 or 8
  assign is_sfr_o = (bit_addr_i >= `COA_BIT_RAM_LIMIT);
  assign bit_pos_o = bit_addr_i[2:0];
  assign byte_addr_o = is_sfr_o ? (bit_addr_i & `COA_BIT_SFR_MASK) :
                       (`COA_BIT_RAM_BASE + {4'h0, bit_addr_i[6:3]});
endmodule // coa_bit_map

// *** testbench/coa_operand_addressing_monitor.sv ***
`timescale 1ns/10ps
module coa_monitor (
  input wire core_clk_i, nrst_i, decode_valid_i, addr_valid_o,
  input wire [7:0] opcode_i, operand_byte1_i, operand_byte2_i, accumulator_i, status_word_i,
  input wire [7:0] indirect_pointer_zero_i, indirect_pointer_one_i, immediate_o,
  input wire [15:0] data_pointer_i, operand_addr_o,
  input wire [2:0] addr_space_o, addr_mode_o, bit_pos_o, reg_index_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  wire v = decode_valid_i;
  wire [7:0] o = opcode_i;
  wire [7:0] p0 = indirect_pointer_zero_i;
  property p_lat; v |=> addr_valid_o; endproperty
  a_lat: assert property (p_lat) else $error("valid late");
  property p_hold; !v |=> $stable(operand_addr_o); endproperty
  a_hold: assert property (p_hold) else $error("addr moved");
  property p_dir; v && o == 8'hE5 |=> operand_addr_o == $past(operand_byte1_i); endproperty
  a_dir: assert property (p_dir) else $error("direct addr");
  property p_ind; v && o == 8'hE6 |=> operand_addr_o == $past(p0); endproperty
  a_ind: assert property (p_ind) else $error("ind8 addr");
  property p_data_pointer; v && o == 8'hE0 |=> operand_addr_o == $past(data_pointer_i); endproperty
  a_data_pointer: assert property (p_data_pointer) else $error("ind16 addr");
  property p_reg; v && o[7:3] == 5'h1D |=> reg_index_o == $past(o[2:0]); endproperty
  a_reg: assert property (p_reg) else $error("reg index");
  property p_imm; v && o == 8'h74 |=> immediate_o == $past(operand_byte1_i); endproperty
  a_imm: assert property (p_imm) else $error("immediate");
  property p_idx; v && o == 8'h93 |=> operand_addr_o == $past(data_pointer_i) + $past(accumulator_i); endproperty
  a_idx: assert property (p_idx) else $error("indexed addr");
  property p_bit; v && o == 8'hD2 && !operand_byte1_i[7] |=>
    operand_addr_o == 16'h0020 + $past(operand_byte1_i[6:3]) &&
    bit_pos_o == $past(operand_byte1_i[2:0]); endproperty
  a_bit: assert property (p_bit) else $error("bit ram byte");
  property p_impl; v && o == 8'hE4 |=> addr_space_o == 3'h7; endproperty
  a_impl: assert property (p_impl) else $error("implied space");
endmodule // coa_monitor
bind coa_operand_addressing coa_monitor u_mon (.*);

// *** testbench/coa_ram_model.sv ***
`timescale 1ns/10ps
module coa_ram_model (
  input wire [7:0] status_word_i,
  output wire [7:0] indirect_pointer_zero_o,
  output wire [7:0] indirect_pointer_one_o
);
  // bank pointers held in low ram, patterned
  assign indirect_pointer_zero_o = {3'h0, status_word_i[4:3], 3'h0} ^ 8'hA5;
  assign indirect_pointer_one_o = {3'h0, status_word_i[4:3], 3'h1} ^ 8'hA5;
endmodule // coa_ram_model

// *** testbench/test_cpu_operand_addressing.sv ***
`timescale 1ns/10ps
module test_cpu_operand_addressing;
  logic core_clk_i = 0, nrst_i = 0, decode_valid_i = 0;
  logic [7:0] opcode_i = 8'h00, operand_byte1_i = 8'h00, operand_byte2_i = 8'h00;
  logic [7:0] accumulator_i = 8'hF0, status_word_i = 8'h00;
  logic [15:0] data_pointer_i = 16'h12F0;
  wire [7:0] indirect_pointer_zero_i, indirect_pointer_one_i, immediate_o;
  wire addr_valid_o;
  wire [2:0] addr_space_o, addr_mode_o, bit_pos_o, reg_index_o;
  wire [15:0] operand_addr_o;
  int errors = 0, check_count = 0, cyc = 0;
  coa_operand_addressing dut (.*);
  coa_ram_model ram (.status_word_i, .indirect_pointer_zero_o(indirect_pointer_zero_i),
    .indirect_pointer_one_o(indirect_pointer_one_i));
  initial forever #25 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) if (++cyc == 400) begin
    errors++;
    give_verdict();
  end
  task chk(string n, logic [15:0] e, g);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task op(logic [7:0] o, b);
    @(negedge core_clk_i);
    {decode_valid_i, opcode_i, operand_byte1_i} = {1'b1, o, b};
    @(negedge core_clk_i);
    decode_valid_i = 0;
    chk("vld", 1, addr_valid_o);
  endtask
  task t_addr;
    op(8'hE5, 8'h7F);
    chk("dir", 16'h207F, {addr_space_o, operand_addr_o[12:0]});
    op(8'hE5, 8'h81);
    chk("sfr", 16'h4081, {addr_space_o, operand_addr_o[12:0]});
    for (int b = 0; b < 4; b++) begin
      status_word_i = 8'(b * 8);
      op(8'hE6, 8'h00);
      chk("ind0", 8'(b * 8) ^ 8'hA5, operand_addr_o);
      op(8'hE7, 8'h00);
      chk("ind1", 8'(b * 8 + 1) ^ 8'hA5, operand_addr_o);
    end
    op(8'hE0, 8'h00);
    chk("data_pointer", 16'h72F0, {addr_space_o, operand_addr_o[12:0]});
    op(8'h93, 8'h00);
    chk("code", 16'h93E0, {addr_space_o, operand_addr_o[12:0]});
    $display("addr test done");
  endtask
  task t_reg;
    for (int i = 0; i < 32; i++) begin
      status_word_i = 8'(i & 24);
      op(8'hE8 | 8'(i & 7), 8'h00);
      chk("reg", {3'(i & 7), 13'(i)}, {reg_index_o, operand_addr_o[12:0]});
    end
    $display("reg test done");
  endtask
  task t_misc;
    op(8'hE4, 8'h00);
    chk("impl", 16'h0507, {addr_mode_o, 5'h00, addr_space_o});
    op(8'h74, 8'h5A);
    chk("imm", 16'h065A, {addr_mode_o, immediate_o});
    operand_byte2_i = 8'hC3;
    op(8'h75, 8'h30);
    chk("dir_imm", 16'h01C3, {addr_mode_o, immediate_o});
    chk("dir_imm_addr", 16'h2030, {addr_space_o, operand_addr_o[12:0]});
    op(8'hD2, 8'h7F);
    chk("bit_ram", 16'hE02F, {bit_pos_o, operand_addr_o[12:0]});
    op(8'hD2, 8'h80);
    chk("bit_sfr", 16'h0080, {bit_pos_o, operand_addr_o[12:0]});
    $display("misc test done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge core_clk_i);
    chk("rst", 16'h0000, operand_addr_o);
    nrst_i = 1;
    t_addr();
    t_reg();
    t_misc();
    give_verdict();
  end
endmodule // test_cpu_operand_addressing
